// ### core/pll_clock_pkg.sv
// Package: constants for the PLL and core clock divider control block.
// Assumes a single reference clock domain and an 8-bit special function register port.
package pll_clock_pkg;
  localparam logic [7:0] PLL_CLOCK_CONTROL_ADDR = 8'hD7;
  localparam logic [7:0] PLL_CLOCK_CONTROL_RST  = 8'h53;
  localparam int         OSCILLATOR_POWERDOWN_BIT_BIT             = 7;
  localparam int         LOCK_BIT               = 6;
  localparam int         EXT_ACCESS_BIT         = 4;
  localparam int         FAST_INT_BIT           = 3;
  localparam int         DIV_MSB                = 2;
  localparam int         DIV_W                  = 3;
  localparam logic [2:0] DIV_FASTEST            = 3'h0;
  localparam logic [2:0] DIV_DEFAULT            = 3'h3;
  localparam int         PLL_MULT               = 384;
  localparam int         PRESCALE_W            = 8;
  localparam int         LOCK_CNT_W            = 16;
endpackage

// ### core/clk_gate_if.sv
// Interface: carries divider select and clock enable between top and divider.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface clk_gate_if;
  logic [2:0] div_sel;
  logic       core_tick;
  logic       edge_boundary;
  modport ctrl (output div_sel, input core_tick, input edge_boundary);
  modport div  (input div_sel, output core_tick, output edge_boundary);
endinterface

// ### core/core_clk_divider.sv
// Core clock divider: a free running counter makes a tick every 2^div_sel cycles.
// Assumes the selection only changes at edge boundaries reported back to the control.
`timescale 1ns/1ps
module core_clk_divider (
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic rst_n,
  // Divider link
  clk_gate_if.div   gi
);
  logic [6:0] cnt_r;
  logic [6:0] mask;
  assign mask = 7'((8'h01 << gi.div_sel) - 8'h01);
  // A new ratio applies only when the count has wrapped, so no pulse is cut
  assign gi.edge_boundary = ((cnt_r & mask) == mask);
  assign gi.core_tick     = gi.edge_boundary;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= 7'h00;
    end else if (gi.edge_boundary) begin
      cnt_r <= 7'h00;
    end else begin
      cnt_r <= cnt_r + 7'h01;
    end
  end
endmodule

// ### core/pll_core_clock_control.sv
// PLL and core clock control register with divider, lock and strap status.
// Assumes ref_clk is the PLL output; crystal tick, pll lock and strap pins are asynchronous.
//
// Function
// - PLL runs at 384 times crystal.
// - Modulator clock tick follows crystal rate.
// - Core clock is PLL over two power field.
// - Divider resets to three, PLL over eight.
// - Low-voltage part ignores writes of divider zero.
// - Bit seven stops oscillator in power-down.
// - Seconds counter runs in power-down when kept.
// - Bit six reports PLL lock status.
// - Bit four returns strap latched at reset.
// - Fast interrupt bit uses fastest clock while an interrupt is active.
// - Fast interrupt forces divider field to zero.
`timescale 1ns/1ps
module pll_core_clock_control #(
  parameter bit LOW_VOLTAGE = 1'b0
) (
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  // Special function register port
  input  wire logic [7:0] sfr_addr,
  input  wire logic       sfr_wr,
  input  wire logic       sfr_rd,
  input  wire logic [7:0] sfr_wdata,
  output logic      [7:0] sfr_rdata,
  output logic            sfr_sel,
  // Analog and pin status
  input  wire logic       pll_locked_in,
  input  wire logic       external_access_pin,
  input  wire logic       xtal_tick,
  // Power and interrupt context
  input  wire logic       power_down,
  input  wire logic       irq_active,
  // Clock outputs
  output logic            core_clk_en,
  output logic            modulator_clk_en,
  output logic            osc_enable,
  output logic            seconds_count_en,
  output logic [2:0]      core_divider_field
);
  logic [1:0] lock_sync_r;
  logic [1:0] ea_sync_r;
  logic [2:0] xt_sync_r;
  logic       ea_capture_r;
  logic       latched_ext_access_status_r;
  logic       oscillator_powerdown_bit_r;
  logic       fast_interrupt_enable_r;
  logic [2:0] core_divider_bits_r;
  logic [2:0] core_divider_bits_nxt;
  logic [2:0] active_div_r;
  logic       modulator_tick_r;
  logic       hit;
  logic       wr_en;
  logic       div_zero_blocked;
  logic [2:0] wanted_div;
  logic [2:0] wr_div;
  logic [7:0] reg_view;
  clk_gate_if gi ();

  core_clk_divider u_div (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .gi      (gi)
  );

  // Fast interrupt forcing picks the fastest ratio over the stored one
  function automatic logic [2:0] pick_div(input logic force_fast, input logic [2:0] stored);
    pick_div = force_fast ? pll_clock_pkg::DIV_FASTEST : stored;
  endfunction

  assign hit   = (sfr_addr == pll_clock_pkg::PLL_CLOCK_CONTROL_ADDR);
  assign wr_en = hit && sfr_wr;
  assign wr_div = sfr_wdata[pll_clock_pkg::DIV_MSB:0];
  assign div_zero_blocked = LOW_VOLTAGE && (wr_div == pll_clock_pkg::DIV_FASTEST);
  assign core_divider_bits_nxt = (wr_en && !div_zero_blocked) ? wr_div : core_divider_bits_r;
  // Fast interrupt overrides the stored ratio while an interrupt is serviced
  assign wanted_div = pick_div(fast_interrupt_enable_r && irq_active,
                               core_divider_bits_r);
  assign gi.div_sel = active_div_r;

  assign reg_view = {oscillator_powerdown_bit_r,
                     lock_sync_r[1],
                     1'b0,
                     latched_ext_access_status_r,
                     fast_interrupt_enable_r,
                     core_divider_field};
  assign sfr_sel = hit && sfr_rd;

  // Field reads back zero while fast interrupt is enabled, as the hardware forces it
  assign core_divider_field = pick_div(fast_interrupt_enable_r, core_divider_bits_r);
  assign core_clk_en      = gi.core_tick;
  assign modulator_clk_en = modulator_tick_r;
  assign osc_enable       = !(power_down && oscillator_powerdown_bit_r);
  assign seconds_count_en = osc_enable && xt_sync_r[1];

  // Synchronisers for asynchronous inputs
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      lock_sync_r <= 2'h0;
      xt_sync_r   <= 3'h0;
    end else begin
      lock_sync_r <= {lock_sync_r[0], pll_locked_in};
      xt_sync_r   <= {xt_sync_r[1:0], xtal_tick};
    end
  end

  // Strap stages carry no reset, so the pin level has settled when reset ends
  always_ff @(posedge ref_clk) begin
    ea_sync_r <= {ea_sync_r[0], external_access_pin};
  end

  // Strap is caught once, after reset release, when the synchroniser has settled
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ea_capture_r                <= 1'b1;
      latched_ext_access_status_r <= 1'b0;
    end else if (ea_capture_r) begin
      ea_capture_r                <= 1'b0;
      latched_ext_access_status_r <= ea_sync_r[1];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      oscillator_powerdown_bit_r <= pll_clock_pkg::PLL_CLOCK_CONTROL_RST[pll_clock_pkg::OSCILLATOR_POWERDOWN_BIT_BIT];
      fast_interrupt_enable_r    <= pll_clock_pkg::PLL_CLOCK_CONTROL_RST[pll_clock_pkg::FAST_INT_BIT];
      core_divider_bits_r        <= pll_clock_pkg::DIV_DEFAULT;
    end else begin
      if (wr_en) begin
        oscillator_powerdown_bit_r <= sfr_wdata[pll_clock_pkg::OSCILLATOR_POWERDOWN_BIT_BIT];
        fast_interrupt_enable_r    <= sfr_wdata[pll_clock_pkg::FAST_INT_BIT];
      end
      core_divider_bits_r <= core_divider_bits_nxt;
    end
  end

  // Active ratio changes only when the divider is at a wrap point
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      active_div_r <= pll_clock_pkg::DIV_DEFAULT;
    end else if (gi.edge_boundary) begin
      active_div_r <= wanted_div;
    end
  end

  // Rising edge of the synchronised crystal tick gives one modulator pulse
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      modulator_tick_r <= 1'b0;
    end else begin
      modulator_tick_r <= xt_sync_r[1] && !xt_sync_r[2];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sfr_rdata <= 8'h00;
    end else begin
      sfr_rdata <= sfr_sel ? reg_view : 8'h00;
    end
  end

  property p_div_reset;
    @(posedge ref_clk) $rose(rst_n) |-> core_divider_bits_r == pll_clock_pkg::DIV_DEFAULT;
  endproperty
  a_div_reset: assert property (p_div_reset) else $error("divider not default");

  property p_zero_ignored;
    @(posedge ref_clk) disable iff (!rst_n)
      (wr_en && LOW_VOLTAGE && sfr_wdata[2:0] == 3'h0) |=> $stable(core_divider_bits_r);
  endproperty
  a_zero_ignored: assert property (p_zero_ignored) else $error("zero divider accepted");

  property p_write_taken;
    @(posedge ref_clk) disable iff (!rst_n)
      (wr_en && !div_zero_blocked) |=> core_divider_bits_r == $past(sfr_wdata[2:0]);
  endproperty
  a_write_taken: assert property (p_write_taken) else $error("divider write lost");

  property p_fast_interrupt_enable_zero;
    @(posedge ref_clk) disable iff (!rst_n)
      fast_interrupt_enable_r |-> core_divider_field == 3'h0;
  endproperty
  a_fast_interrupt_enable_zero: assert property (p_fast_interrupt_enable_zero) else $error("fast int not forcing zero");

  property p_oscillator_powerdown_bit;
    @(posedge ref_clk) disable iff (!rst_n)
      (power_down && oscillator_powerdown_bit_r) |-> !osc_enable && !seconds_count_en;
  endproperty
  a_oscillator_powerdown_bit: assert property (p_oscillator_powerdown_bit) else $error("oscillator not stopped");

  property p_seconds;
    @(posedge ref_clk) disable iff (!rst_n)
      (!oscillator_powerdown_bit_r && xt_sync_r[1]) |-> seconds_count_en;
  endproperty
  a_seconds: assert property (p_seconds) else $error("seconds counter stopped");

  property p_lock_read;
    @(posedge ref_clk) disable iff (!rst_n)
      sfr_sel |=> sfr_rdata[pll_clock_pkg::LOCK_BIT] == $past(lock_sync_r[1]);
  endproperty
  a_lock_read: assert property (p_lock_read) else $error("lock bit mismatch");

  property p_strap_hold;
    @(posedge ref_clk) disable iff (!rst_n)
      !ea_capture_r && !$past(ea_capture_r) |-> $stable(latched_ext_access_status_r);
  endproperty
  a_strap_hold: assert property (p_strap_hold) else $error("strap status moved");

  property p_clean_switch;
    @(posedge ref_clk) disable iff (!rst_n)
      !gi.edge_boundary |=> $stable(active_div_r);
  endproperty
  a_clean_switch: assert property (p_clean_switch) else $error("ratio changed mid period");

  property p_fast_irq;
    @(posedge ref_clk) disable iff (!rst_n)
      (fast_interrupt_enable_r && irq_active && gi.edge_boundary) |=> active_div_r == 3'h0;
  endproperty
  a_fast_irq: assert property (p_fast_irq) else $error("fast interrupt not fastest");

  property p_active_reset;
    @(posedge ref_clk)
      $rose(rst_n) |-> active_div_r == pll_clock_pkg::DIV_DEFAULT;
  endproperty
  a_active_reset: assert property (p_active_reset) else $error("ratio not default");

  property p_tick_single;
    @(posedge ref_clk) disable iff (!rst_n)
      (core_clk_en && active_div_r != pll_clock_pkg::DIV_FASTEST &&
       wanted_div != pll_clock_pkg::DIV_FASTEST) |=> !core_clk_en;
  endproperty
  a_tick_single: assert property (p_tick_single) else $error("core tick too long");

  property p_fastest_every;
    @(posedge ref_clk) disable iff (!rst_n)
      active_div_r == pll_clock_pkg::DIV_FASTEST |-> core_clk_en;
  endproperty
  a_fastest_every: assert property (p_fastest_every) else $error("fastest tick missing");

  property p_write_pd;
    @(posedge ref_clk) disable iff (!rst_n)
      wr_en |=> oscillator_powerdown_bit_r == $past(sfr_wdata[pll_clock_pkg::OSCILLATOR_POWERDOWN_BIT_BIT]);
  endproperty
  a_write_pd: assert property (p_write_pd) else $error("power-down bit lost");

  property p_write_fast_interrupt_enable;
    @(posedge ref_clk) disable iff (!rst_n)
      wr_en |=> fast_interrupt_enable_r == $past(sfr_wdata[pll_clock_pkg::FAST_INT_BIT]);
  endproperty
  a_write_fast_interrupt_enable: assert property (p_write_fast_interrupt_enable) else $error("fast interrupt bit lost");

  property p_osc_normal;
    @(posedge ref_clk) disable iff (!rst_n)
      !power_down |-> osc_enable;
  endproperty
  a_osc_normal: assert property (p_osc_normal) else $error("oscillator off in run");

  property p_osc_kept;
    @(posedge ref_clk) disable iff (!rst_n)
      (power_down && !oscillator_powerdown_bit_r) |-> osc_enable;
  endproperty
  a_osc_kept: assert property (p_osc_kept) else $error("oscillator not kept");

  property p_seconds_idle;
    @(posedge ref_clk) disable iff (!rst_n)
      !xt_sync_r[1] |-> !seconds_count_en;
  endproperty
  a_seconds_idle: assert property (p_seconds_idle) else $error("seconds enable stray");

  property p_strap_capture;
    @(posedge ref_clk) disable iff (!rst_n)
      ea_capture_r |=> latched_ext_access_status_r == $past(ea_sync_r[1]);
  endproperty
  a_strap_capture: assert property (p_strap_capture) else $error("strap not captured");

  property p_capture_once;
    @(posedge ref_clk) disable iff (!rst_n)
      !ea_capture_r |=> !ea_capture_r;
  endproperty
  a_capture_once: assert property (p_capture_once) else $error("strap captured twice");

  property p_stored_ratio;
    @(posedge ref_clk) disable iff (!rst_n)
      (!(fast_interrupt_enable_r && irq_active) && gi.edge_boundary) |=>
        active_div_r == $past(core_divider_bits_r);
  endproperty
  a_stored_ratio: assert property (p_stored_ratio) else $error("ratio not restored");

  property p_field_stored;
    @(posedge ref_clk) disable iff (!rst_n)
      !fast_interrupt_enable_r |-> core_divider_field == core_divider_bits_r;
  endproperty
  a_field_stored: assert property (p_field_stored) else $error("field not stored");

  property p_mod_single;
    @(posedge ref_clk) disable iff (!rst_n)
      modulator_clk_en |=> !modulator_clk_en;
  endproperty
  a_mod_single: assert property (p_mod_single) else $error("modulator tick too long");
endmodule

// ### verification/xtal_model.sv
// Crystal model: a 32.768 kHz square wave seen from the PLL clock domain.
// Assumes ref_clk stands for the PLL output at 384 times the crystal rate.
`timescale 1ns/1ps
module xtal_model #(
  parameter int HALF = 192
) (
  // Clock
  input  wire logic ref_clk,
  // Oscillator control
  input  wire logic osc_enable,
  output logic      xtal_tick
);
  int cnt = 0;
  initial xtal_tick = 1'b0;
  // A stopped oscillator holds its last level, as a real crystal amplifier does
  always @(posedge ref_clk) begin
    if (osc_enable) begin
      cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
      if (cnt == HALF - 1) xtal_tick <= ~xtal_tick;
    end
  end
endmodule

// ### verification/test_pll_core_clock_control.sv
// Testbench for the PLL and core clock control register, 5 V and 3 V variants.
// Assumes the register port is driven at falling edges and read one cycle later.
`timescale 1ns/1ps
module test_pll_core_clock_control;
  logic             ref_clk, rst_n, sfr_wr, sfr_rd, lock, ea, pwr_dn, irq;
  logic [7:0]       sfr_addr, sfr_wdata, v;
  wire  logic [7:0] rdata, rdata_lv;
  wire  logic [2:0] field, field_lv;
  wire  logic       sel, core_en, mod_en, osc_en, sec_en, xtal;
  int               fails = 0;
  int               check_count = 0;
  int               n;
  logic [7:0]       w_row [6] = '{8'h02, 8'h80, 8'h07, 8'h0C, 8'h74, 8'h81};
  logic [7:0]       r_row [6] = '{8'h52, 8'hD0, 8'h57, 8'h58, 8'h54, 8'hD1};

  pll_core_clock_control u_pll_core_clock_control (.ref_clk(ref_clk), .rst_n(rst_n),
    .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
    .sfr_rdata(rdata), .sfr_sel(sel), .pll_locked_in(lock), .external_access_pin(ea),
    .xtal_tick(xtal), .power_down(pwr_dn), .irq_active(irq), .core_clk_en(core_en),
    .modulator_clk_en(mod_en), .osc_enable(osc_en), .seconds_count_en(sec_en),
    .core_divider_field(field));
  // Low-voltage variant shares every input; only its register view is watched
  pll_core_clock_control #(.LOW_VOLTAGE(1'b1)) u_lv (.ref_clk(ref_clk), .rst_n(rst_n),
    .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
    .sfr_rdata(rdata_lv), .sfr_sel(), .pll_locked_in(lock), .external_access_pin(ea),
    .xtal_tick(xtal), .power_down(pwr_dn), .irq_active(irq), .core_clk_en(),
    .modulator_clk_en(), .osc_enable(), .seconds_count_en(), .core_divider_field(field_lv));
  xtal_model u_xtal_model (.ref_clk(ref_clk), .osc_enable(osc_en), .xtal_tick(xtal));

  task automatic test_done;
    if (fails == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] d);
    sfr_addr = 8'hD7;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(negedge ref_clk);
    sfr_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    sfr_addr = a;
    sfr_rd = 1'b1;
    #5 chk("select", {15'h0, a == 8'hD7}, {15'h0, sel});
    @(negedge ref_clk);
    sfr_rd = 1'b0;
    d = rdata;
  endtask
  // Second gap is measured so a pending ratio change has landed
  task automatic gap(input bit m, output int g);
    int k;
    g = 0;
    repeat (2) begin
      for (k = 0; k < 900 && (m ? mod_en : core_en) !== 1'b1; k++) @(negedge ref_clk);
      @(negedge ref_clk);
      for (g = 1; g < 900 && (m ? mod_en : core_en) !== 1'b1; g++) @(negedge ref_clk);
      if (k == 900 || g == 900) begin
        fails++;
        test_done();
      end
    end
  endtask

  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  initial begin
    rst_n = 1'b0;
    {sfr_wr, sfr_rd, pwr_dn, irq} = 4'h0;
    {sfr_addr, sfr_wdata} = 16'h0;
    lock = 1'b1;
    ea = 1'b1;
    repeat (8) @(negedge ref_clk);
    rst_n = 1'b1;
    repeat (3) @(negedge ref_clk);
    ea = 1'b0;
    rd(8'hD7, v);
    chk("reset value", 8'h53, v);
    gap(1'b0, n);
    chk("default core gap", 16'd8, n);
    for (int i = 0; i < 6; i++) begin
      wr(w_row[i]);
      rd(8'hD7, v);
      chk("register row", r_row[i], v);
      chk("divider field row", r_row[i][2:0], field);
    end
    for (int d = 0; d < 8; d++) begin
      wr(8'(d));
      gap(1'b0, n);
      chk("core gap", 16'(1 << d), n);
    end
    irq = 1'b1;
    wr(8'h0B);
    chk("fast field", 3'h0, field);
    gap(1'b0, n);
    chk("fast irq gap", 16'd1, n);
    irq = 1'b0;
    gap(1'b0, n);
    chk("stored gap", 16'd8, n);
    pwr_dn = 1'b1;
    wr(8'h83);
    chk("osc stopped", 1'b0, osc_en);
    chk("seconds stopped", 1'b0, sec_en);
    @(negedge ref_clk);
    wr(8'h03);
    chk("osc kept", 1'b1, osc_en);
    gap(1'b1, n);
    chk("modulator gap", 16'd384, n);
    chk("seconds kept", 1'b1, sec_en);
    pwr_dn = 1'b0;
    lock = 1'b0;
    repeat (3) @(negedge ref_clk);
    rd(8'hD7, v);
    chk("unlocked", 8'h13, v);
    lock = 1'b1;
    // Software waits for lock after wake-up, with a bounded poll
    for (n = 0; n < 8 && v[6] !== 1'b1; n++) begin
      @(negedge ref_clk);
      rd(8'hD7, v);
    end
    chk("lock after wake", 1'b1, v[6]);
    wr(8'h02);
    @(negedge ref_clk);
    wr(8'h80);
    rd(8'hD7, v);
    chk("lv zero refused", 8'hD2, rdata_lv);
    chk("lv field", 3'h2, field_lv);
    chk("hv zero taken", 3'h0, field);
    chk("hv zero read", 8'hD0, v);
    @(negedge ref_clk);
    rd(8'hD8, v);
    chk("unmapped read", 8'h00, v);
    rst_n = 1'b0;
    repeat (2) @(negedge ref_clk);
    rst_n = 1'b1;
    repeat (4) @(negedge ref_clk);
    rd(8'hD7, v);
    chk("second reset", 8'h43, v);
    test_done();
  end
endmodule
